/* File: hdl/ccu_pkg.sv */
/*
  Shared types and constants of the code conversion unit.
  Assumes a single clock domain; operands are prepared by the sequencer.
*/
package ccu_pkg;

  // ----------------------------------------------------------------
  // Widths and limits
  // ----------------------------------------------------------------
  localparam int unsigned WORD_W   = 16;
  localparam int unsigned CHAR_W   = 8;
  localparam int unsigned MAX_CHAR = 16;
  localparam int unsigned NIB_W    = 4;
  localparam int unsigned DIGITS   = 4;
  localparam int unsigned CNT_W    = 5;
  localparam int unsigned TBL_W    = MAX_CHAR * CHAR_W;

  localparam logic [WORD_W-1:0] DEC_MAX   = 16'h270f;
  localparam logic [NIB_W-1:0]  DIGIT_MAX = 4'h9;
  localparam logic [NIB_W-1:0]  DD_ADD_AT = 4'h5;
  localparam logic [NIB_W-1:0]  DD_ADD    = 4'h3;
  localparam logic [WORD_W-1:0] DEC_TEN   = 16'h000a;
  localparam logic [CNT_W-1:0]  CNT_MAX   = 5'h10;

  // ----------------------------------------------------------------
  // Segment patterns, bit 0 is the top segment, bit 7 always clear
  // ----------------------------------------------------------------
  localparam logic [7:0] SEG_TBL [16] = '{
    8'h3f, 8'h06, 8'h5b, 8'h4f, 8'h66, 8'h6d, 8'h7d, 8'h27,
    8'h7f, 8'h6f, 8'h77, 8'h7c, 8'h39, 8'h5e, 8'h79, 8'h71
  };

  // ----------------------------------------------------------------
  // Functions and carriers
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    CCU_FN_SEG  = 2'b00,
    CCU_FN_TEXT = 2'b01,
    CCU_FN_D2B  = 2'b10,
    CCU_FN_B2D  = 2'b11
  } ccu_fn_t;

  typedef struct packed {
    ccu_fn_t           fn;
    logic [WORD_W-1:0] src;
    logic [TBL_W-1:0]  text;
    logic [CNT_W-1:0]  char_cnt;
  } ccu_req_t;

  typedef struct packed {
    logic              out_flag;
    logic              fault_flag_bit;
    logic              dst_we;
    logic [WORD_W-1:0] dst_data;
    logic              tbl_we;
    logic [MAX_CHAR-1:0] tbl_be;
    logic [TBL_W-1:0]  tbl_data;
  } ccu_res_t;

endpackage

/* File: hdl/ccu_top.sv */
/*
  Code conversion unit: segment decode, text to character codes,
  packed decimal to plain value and plain value to packed decimal.
  Assumes the request and condition come from logic on clk and that
  the sequencer applies dst and table writes to its register file.
*/
// What this block does
// - Segment decode: low nibble in, high byte zero
// - Digits 0-9 map to fixed segment patterns
// - Nibbles A-F map to patterns, bit 7 clear
// - Condition off: no action, output flag low
// - Up to 16 characters, one byte each, low first
// - Only converted bytes written, rest kept
// - Four packed decimal digits become plain value
// - Bad digit: no write, flag low, fault set
// - Value 0..9999 becomes four packed digits
// - Value out of range: no write, fault set
// - Fault stays set until explicitly cleared
`timescale 1ns/1ps
`default_nettype none

module ccu_top (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst_n,
  // Request from the sequencer
  input  wire logic             cond,
  input  wire ccu_pkg::ccu_req_t req,
  input  wire logic             fault_clr,
  // Results
  output var  ccu_pkg::ccu_res_t res
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic digits_ok(input logic [15:0] v);
    logic ok;
    ok = 1'b1;
    for (int i = 0; i < ccu_pkg::DIGITS; i++) begin
      if (v[i*ccu_pkg::NIB_W +: ccu_pkg::NIB_W] > ccu_pkg::DIGIT_MAX) begin
        ok = 1'b0;
      end
    end
    return ok;
  endfunction

  function automatic logic [15:0] digits_to_value(input logic [15:0] v);
    logic [15:0] acc;
    acc = '0;
    for (int i = ccu_pkg::DIGITS - 1; i >= 0; i--) begin
      acc = 16'(acc * ccu_pkg::DEC_TEN
                + 16'(v[i*ccu_pkg::NIB_W +: ccu_pkg::NIB_W]));
    end
    return acc;
  endfunction

  // Shift-and-add-three conversion
  function automatic logic [15:0] value_to_digits(input logic [15:0] v);
    logic [15:0] bcd;
    bcd = '0;
    for (int b = ccu_pkg::WORD_W - 1; b >= 0; b--) begin
      for (int d = 0; d < ccu_pkg::DIGITS; d++) begin
        if (bcd[d*ccu_pkg::NIB_W +: ccu_pkg::NIB_W] >= ccu_pkg::DD_ADD_AT)
        begin
          bcd[d*ccu_pkg::NIB_W +: ccu_pkg::NIB_W] =
            bcd[d*ccu_pkg::NIB_W +: ccu_pkg::NIB_W] + ccu_pkg::DD_ADD;
        end
      end
      bcd = {bcd[14:0], v[b]};
    end
    return bcd;
  endfunction

  function automatic logic [ccu_pkg::MAX_CHAR-1:0] byte_mask(
    input logic [ccu_pkg::CNT_W-1:0] n);
    logic [ccu_pkg::MAX_CHAR-1:0] m;
    m = '0;
    for (int i = 0; i < ccu_pkg::MAX_CHAR; i++) begin
      if (ccu_pkg::CNT_W'(i) < n) begin
        m[i] = 1'b1;
      end
    end
    return m;
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  ccu_pkg::ccu_res_t st_r;
  ccu_pkg::ccu_res_t st_nxt;
  logic [ccu_pkg::CNT_W-1:0] cnt_lim;

  assign cnt_lim = (req.char_cnt > ccu_pkg::CNT_MAX) ? ccu_pkg::CNT_MAX
                                                     : req.char_cnt;

  always_comb begin
    st_nxt          = st_r;
    st_nxt.out_flag = 1'b0;
    st_nxt.dst_we   = 1'b0;
    st_nxt.tbl_we   = 1'b0;
    st_nxt.tbl_be   = '0;
    if (fault_clr) begin
      st_nxt.fault_flag_bit = 1'b0;
    end
    if (cond) begin
      case (req.fn)
        ccu_pkg::CCU_FN_SEG: begin
          st_nxt.dst_data = {8'h00,
                             ccu_pkg::SEG_TBL[req.src[3:0]]};
          st_nxt.dst_we   = 1'b1;
          st_nxt.out_flag = 1'b1;
        end
        ccu_pkg::CCU_FN_TEXT: begin
          st_nxt.tbl_data = req.text;
          st_nxt.tbl_be   = byte_mask(cnt_lim);
          st_nxt.tbl_we   = 1'b1;
          st_nxt.out_flag = 1'b1;
        end
        ccu_pkg::CCU_FN_D2B: begin
          if (digits_ok(req.src)) begin
            st_nxt.dst_data = digits_to_value(req.src);
            st_nxt.dst_we   = 1'b1;
            st_nxt.out_flag = 1'b1;
          end else begin
            st_nxt.fault_flag_bit = 1'b1;
          end
        end
        ccu_pkg::CCU_FN_B2D: begin
          // Unsigned compare also rejects negative values
          if (req.src <= ccu_pkg::DEC_MAX) begin
            st_nxt.dst_data = value_to_digits(req.src);
            st_nxt.dst_we   = 1'b1;
            st_nxt.out_flag = 1'b1;
          end else begin
            st_nxt.fault_flag_bit = 1'b1;
          end
        end
        default: begin
          st_nxt.out_flag = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign res = st_r;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  logic past_ok;
  always_ff @(posedge clk) begin
    past_ok <= rst_n;
  end

  AST_SEG_HIGH_ZERO: assert property (
    past_ok && $past(cond && req.fn == ccu_pkg::CCU_FN_SEG)
    |-> res.dst_we && res.dst_data[15:8] == 8'h00)
    else $error("segment result upper byte not zero");

  AST_SEG_NINE: assert property (
    past_ok && $past(cond && req.fn == ccu_pkg::CCU_FN_SEG
                     && req.src[3:0] == 4'h9)
    |-> res.dst_data == 16'h006f)
    else $error("segment pattern for nine wrong");

  AST_SEG_HEX: assert property (
    past_ok && $past(cond && req.fn == ccu_pkg::CCU_FN_SEG
                     && req.src[3:0] == 4'ha)
    |-> res.dst_data == 16'h0077 && !res.dst_data[7])
    else $error("segment pattern for A wrong");

  AST_IDLE_QUIET: assert property (
    past_ok && !$past(cond)
    |-> !res.out_flag && !res.dst_we && !res.tbl_we)
    else $error("activity while condition off");

  AST_TEXT_FIRST: assert property (
    past_ok && $past(cond && req.fn == ccu_pkg::CCU_FN_TEXT)
    |-> res.tbl_we && res.out_flag
        && res.tbl_data[7:0] == $past(req.text[7:0]))
    else $error("first character not in low byte");

  AST_TEXT_COUNT: assert property (
    past_ok && $past(cond && req.fn == ccu_pkg::CCU_FN_TEXT
                     && req.char_cnt <= ccu_pkg::CNT_MAX)
    |-> $countones(res.tbl_be) == int'($past(req.char_cnt)))
    else $error("byte enables do not match count");

  AST_TEXT_ODD: assert property (
    past_ok && $past(cond && req.fn == ccu_pkg::CCU_FN_TEXT
                     && req.char_cnt == 5'h05)
    |-> res.tbl_be[5:4] == 2'b01)
    else $error("odd count touched high byte");

  AST_D2B_VALUE: assert property (
    past_ok && $past(cond && req.fn == ccu_pkg::CCU_FN_D2B
                     && req.src == 16'h1234)
    |-> res.dst_we && res.out_flag && res.dst_data == 16'h04d2)
    else $error("decimal to value wrong");

  AST_D2B_BAD: assert property (
    past_ok && $past(cond && req.fn == ccu_pkg::CCU_FN_D2B
                     && !digits_ok(req.src))
    |-> !res.dst_we && !res.out_flag && res.fault_flag_bit)
    else $error("bad digit not refused");

  AST_B2D_VALUE: assert property (
    past_ok && $past(cond && req.fn == ccu_pkg::CCU_FN_B2D
                     && req.src == 16'h1538)
    |-> res.dst_we && res.dst_data == 16'h5432)
    else $error("value to decimal wrong");

  AST_B2D_RANGE: assert property (
    past_ok && $past(cond && req.fn == ccu_pkg::CCU_FN_B2D
                     && req.src > ccu_pkg::DEC_MAX)
    |-> !res.dst_we && !res.out_flag && res.fault_flag_bit)
    else $error("out of range value not refused");

  AST_FAULT_HOLD: assert property (
    past_ok && $past(res.fault_flag_bit && !fault_clr)
    |-> res.fault_flag_bit)
    else $error("fault flag dropped without clear");

  AST_SEG_TOP_CLEAR: assert property (
    past_ok && $past(cond && req.fn == ccu_pkg::CCU_FN_SEG)
    |-> !res.dst_data[7])
    else $error("segment pattern bit 7 set");

  AST_SEG_ZERO: assert property (
    past_ok && $past(cond && req.fn == ccu_pkg::CCU_FN_SEG
                     && req.src[3:0] == 4'h0)
    |-> res.dst_data == 16'h003f)
    else $error("segment pattern for zero wrong");

  AST_SEG_HEX_F: assert property (
    past_ok && $past(cond && req.fn == ccu_pkg::CCU_FN_SEG
                     && req.src[3:0] == 4'hf)
    |-> res.dst_data == 16'h0071)
    else $error("segment pattern for F wrong");

  AST_TEXT_CLAMP: assert property (
    past_ok && $past(cond && req.fn == ccu_pkg::CCU_FN_TEXT
                     && req.char_cnt > ccu_pkg::CNT_MAX)
    |-> &res.tbl_be)
    else $error("long text not clamped to sixteen bytes");

  AST_TEXT_LAST: assert property (
    past_ok && $past(cond && req.fn == ccu_pkg::CCU_FN_TEXT
                     && req.char_cnt == ccu_pkg::CNT_MAX)
    |-> res.tbl_be[15]
        && res.tbl_data[127:120] == $past(req.text[127:120]))
    else $error("sixteenth character not in top byte");

  AST_D2B_HOLD: assert property (
    past_ok && $past(cond && req.fn == ccu_pkg::CCU_FN_D2B
                     && !digits_ok(req.src))
    |-> $stable(res.dst_data))
    else $error("refused decimal changed result word");

  AST_B2D_HOLD: assert property (
    past_ok && $past(cond && req.fn == ccu_pkg::CCU_FN_B2D
                     && req.src > ccu_pkg::DEC_MAX)
    |-> $stable(res.dst_data))
    else $error("refused value changed result word");

  AST_FAULT_SET_WINS: assert property (
    past_ok && $past(fault_clr && cond && req.fn == ccu_pkg::CCU_FN_D2B
                     && !digits_ok(req.src))
    |-> res.fault_flag_bit)
    else $error("clear beat a fault event in the same cycle");

  AST_FAULT_CAUSE: assert property (
    past_ok && $rose(res.fault_flag_bit)
    |-> $past(cond && (req.fn == ccu_pkg::CCU_FN_D2B
                       || req.fn == ccu_pkg::CCU_FN_B2D)))
    else $error("fault flag set without a word conversion");

  AST_D2B_NINES: assert property (
    past_ok && $past(cond && req.fn == ccu_pkg::CCU_FN_D2B
                     && req.src == 16'h9999)
    |-> res.dst_we && res.dst_data == 16'h270f)
    else $error("largest decimal to value wrong");

  COV_SEG: cover property (
    cond && req.fn == ccu_pkg::CCU_FN_SEG ##1 res.out_flag);
  COV_TEXT_ODD: cover property (
    cond && req.fn == ccu_pkg::CCU_FN_TEXT && req.char_cnt[0]
    ##1 res.tbl_we);
  COV_D2B_FAULT: cover property (
    cond && req.fn == ccu_pkg::CCU_FN_D2B ##1 res.fault_flag_bit);
  COV_FAULT_CLEAR: cover property (
    res.fault_flag_bit && fault_clr ##1 !res.fault_flag_bit);
  COV_B2D_FAULT: cover property (
    cond && req.fn == ccu_pkg::CCU_FN_B2D ##1 res.fault_flag_bit);

endmodule

`default_nettype wire

/* File: dv/tb_top.sv */
/*
  Self-checking bench of the code conversion unit.
  Assumes ccu_pkg is compiled first; drives ccu_top ports directly.
*/
`timescale 1ns/1ps
`default_nettype none

module tb_top;

  // ----------------------------------------------------------------
  // Signals and design
  // ----------------------------------------------------------------
  logic              clk;
  logic              rst_n;
  logic              cond;
  logic              fault_clr;
  ccu_pkg::ccu_req_t req;
  ccu_pkg::ccu_res_t res;
  int                error_cnt;
  int                cmp_count;
  int                cyc;

  ccu_top ccu_top_inst (
    .clk       (clk),
    .rst_n     (rst_n),
    .cond      (cond),
    .req       (req),
    .fault_clr (fault_clr),
    .res       (res)
  );

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic end_sim();
    $display("errors %0d compares %0d", error_cnt, cmp_count);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [$bits(ccu_pkg::ccu_res_t)-1:0] got,
                     input logic [$bits(ccu_pkg::ccu_res_t)-1:0] exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic do_op(input ccu_pkg::ccu_fn_t fn, input logic [15:0] src,
                       input logic [127:0] txt, input logic [4:0] cnt);
    @(posedge clk);
    cond <= 1'b1;
    req  <= '{fn: fn, src: src, text: txt, char_cnt: cnt};
    @(posedge clk);
    cond <= 1'b0;
    #1;
  endtask

  task automatic clr_fault();
    @(posedge clk);
    fault_clr <= 1'b1;
    @(posedge clk);
    fault_clr <= 1'b0;
    #1;
    chk(res.fault_flag_bit, 1'b0);
  endtask

  // Result of one accepted or refused word conversion
  task automatic word_op(input ccu_pkg::ccu_fn_t fn, input logic [15:0] src,
                         input logic ok, input logic [15:0] exp);
    do_op(fn, src, '0, 5'h00);
    chk(res.out_flag, ok);
    chk(res.dst_we, ok);
    chk(res.dst_data, exp);
    if (!ok) chk(res.fault_flag_bit, 1'b1);
  endtask

  task automatic test_seg();
    logic [7:0] seg [16];
    seg = '{8'h3f, 8'h06, 8'h5b, 8'h4f, 8'h66, 8'h6d, 8'h7d, 8'h27,
            8'h7f, 8'h6f, 8'h77, 8'h7c, 8'h39, 8'h5e, 8'h79, 8'h71};
    for (int i = 0; i < 16; i++) begin
      word_op(ccu_pkg::CCU_FN_SEG, 16'hfa50 | 16'(i), 1'b1, {8'h00, seg[i]});
      chk(res.dst_data[7], 1'b0);
    end
  endtask

  task automatic test_idle();
    @(posedge clk);
    req.fn <= ccu_pkg::CCU_FN_TEXT;
    repeat (3) @(posedge clk);
    #1;
    chk({res.out_flag, res.dst_we, res.tbl_we}, 3'h0);
  endtask

  task automatic test_text();
    logic [127:0] txt;
    logic [127:0] msk;
    int           cnts [4];
    int           n;
    cnts = '{3, 14, 16, 20};
    for (int i = 0; i < 16; i++) txt[8*i +: 8] = 8'h41 + 8'(i);
    foreach (cnts[k]) begin
      n = (cnts[k] > 16) ? 16 : cnts[k];
      msk = '0;
      for (int i = 0; i < n; i++) msk[8*i +: 8] = 8'hff;
      do_op(ccu_pkg::CCU_FN_TEXT, 16'h0000, txt, 5'(cnts[k]));
      chk({res.out_flag, res.tbl_we}, 2'h3);
      chk(res.tbl_be, 16'((17'h1 << n) - 17'h1));
      chk(res.tbl_data & msk, txt & msk);
    end
  endtask

  task automatic test_d2b();
    word_op(ccu_pkg::CCU_FN_D2B, 16'h1234, 1'b1, 16'h04d2);
    word_op(ccu_pkg::CCU_FN_D2B, 16'h9999, 1'b1, 16'h270f);
    word_op(ccu_pkg::CCU_FN_D2B, 16'h13a6, 1'b0, 16'h270f);
    word_op(ccu_pkg::CCU_FN_D2B, 16'ha000, 1'b0, 16'h270f);
    word_op(ccu_pkg::CCU_FN_SEG, 16'h0001, 1'b1, 16'h0006);
    chk(res.fault_flag_bit, 1'b1);
    clr_fault();
  endtask

  task automatic test_b2d();
    word_op(ccu_pkg::CCU_FN_B2D, 16'h1538, 1'b1, 16'h5432);
    word_op(ccu_pkg::CCU_FN_B2D, 16'h0000, 1'b1, 16'h0000);
    word_op(ccu_pkg::CCU_FN_B2D, 16'h270f, 1'b1, 16'h9999);
    word_op(ccu_pkg::CCU_FN_B2D, 16'h2710, 1'b0, 16'h9999);
    clr_fault();
    word_op(ccu_pkg::CCU_FN_B2D, 16'hffff, 1'b0, 16'h9999);
    clr_fault();
  endtask

  // Fault event and clear in one cycle: the event wins
  task automatic test_set_wins();
    @(posedge clk);
    cond      <= 1'b1;
    fault_clr <= 1'b1;
    req       <= '{fn: ccu_pkg::CCU_FN_D2B, src: 16'h00f0,
                   text: 128'h0, char_cnt: 5'h00};
    @(posedge clk);
    cond      <= 1'b0;
    fault_clr <= 1'b0;
    #1;
    chk(res.fault_flag_bit, 1'b1);
    chk({res.out_flag, res.dst_we}, 2'h0);
    clr_fault();
  endtask

  // ----------------------------------------------------------------
  // Main sequence and hang guard
  // ----------------------------------------------------------------
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      error_cnt++;
      end_sim();
    end
  end

  initial begin
    error_cnt = 0;
    cmp_count = 0;
    cyc       = 0;
    rst_n     = 1'b0;
    cond      = 1'b0;
    fault_clr = 1'b0;
    req       = '0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    #1;
    chk(res, '0);
    test_seg();
    test_idle();
    test_text();
    test_d2b();
    test_b2d();
    test_set_wins();
    end_sim();
  end

endmodule

`default_nettype wire
